// [inc/oscc_pkg.sv]
// package: oscillator control register map, fields and constants
`default_nettype none
package oscc_pkg;
    localparam logic [7:0] OSCC_ADDR_CTRL = 8'h00;
    localparam logic [7:0] OSCC_ADDR_STROBE = 8'h04;
    localparam int OSCC_ADDR_W = 8;
    localparam int OSCC_POS_ODIV = 27;
    localparam int OSCC_POS_FDIV = 24;
    localparam int OSCC_POS_SRDY = 22;
    localparam int OSCC_POS_PRDY = 21;
    localparam int OSCC_POS_PDIV = 19;
    localparam int OSCC_POS_MULT = 16;
    localparam int OSCC_POS_CUR = 12;
    localparam int OSCC_POS_REQ = 8;
    localparam int OSCC_POS_LOCK = 7;
    localparam int OSCC_POS_ULCK = 6;
    localparam int OSCC_POS_SLCK = 5;
    localparam int OSCC_POS_SLP = 4;
    localparam int OSCC_POS_SEN = 1;
    localparam int OSCC_POS_UNLOCK = 0;
    localparam int OSCC_POS_WAIT = 1;
    localparam logic [2:0] OSCC_FDIV_RST = 3'h1;
    localparam logic [31:0] OSCC_UNLOCK_KEY1 = 32'hAA99_6655;
    localparam logic [31:0] OSCC_UNLOCK_KEY2 = 32'h5566_99AA;
    localparam logic [31:0] OSCC_ZERO = 32'h0000_0000;
    localparam logic [8:0] OSCC_DIV_ONE = 9'h001;
    localparam int OSCC_PDIV_SETTLE = 8;
    typedef enum logic [2:0] {
        OSCC_UNL_IDLE = 3'b001,
        OSCC_UNL_KEY1 = 3'b010,
        OSCC_UNL_OPEN = 3'b100
    } oscc_unl_t;
    typedef enum logic [1:0] {
        OSCC_RUN = 2'b01,
        OSCC_WAIT = 2'b10
    } oscc_pwr_t;
endpackage
`default_nettype wire

// [hw/oscc_clk_div.sv]
// clock enable divider: emits one-cycle pulse every ratio cycles
`default_nettype none
module oscc_clk_div #(
    parameter int CW = 9
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [CW-1:0] ratio,
    output logic tick
);
    typedef struct packed {
        logic [CW-1:0] cnt;
        logic tick;
    } oscc_div_t;
    oscc_div_t state;
    oscc_div_t next_state;
    always_comb begin
        next_state = state;
        next_state.tick = 1'b0;
        if (state.cnt + CW'(1) >= ratio) begin
            next_state.cnt = '0;
            next_state.tick = 1'b1;
        end else begin
            next_state.cnt = state.cnt + CW'(1);
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end
    assign tick = state.tick;
endmodule // oscc_clk_div
`default_nettype wire

// [hw/oscc_ctrl.sv]
// oscillator control register with apb slave and clock enables
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`default_nettype none
// Summary of operation
// - pll output divided by 1,2,4,8,16,32,64,256 per output divider field
// - fast rc divided with same encoding; field resets to divide by two
// - secondary ready flag bit 22 high only while that oscillator is stable
// - bit 21 reads 1 when bus divisor writable; resets to 1
// - bus clock is system clock divided by 2,4,8,16; default set by bus divisor config
// - pll multiplier field selects factor 15..21 or 24
// - bits 14-12 report the active oscillator source
// - bits 10-8 hold requested source, same encoding as current
// - requested source loads from boot source config at reset
// - with monitor config 1x, set lock bit freezes clock and pll selections
// - with monitor config 0x, selections never locked
// - bit 6 shows usb pll locked
// - bit 5 shows system pll locked
// - wait enters sleep when bit 4 set, idle otherwise
// - bits 31-30, 23, 15, 11 read zero and ignore writes
// - divider, divisor, multiplier, source, secondary enable load from config
module oscc_ctrl
    import oscc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [oscc_pkg::OSCC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] cfg_pll_out_divider,
    input wire logic [1:0] cfg_periph_bus_divisor,
    input wire logic [2:0] cfg_pll_multiplier,
    input wire logic [2:0] boot_source_cfg,
    input wire logic cfg_secondary_osc_enable,
    input wire logic [1:0] switch_monitor_cfg,
    input wire logic secondary_osc_stable,
    input wire logic usb_pll_lock_in,
    input wire logic system_pll_lock_in,
    input wire logic [2:0] active_source_in,
    input wire logic wait_exec,
    input wire logic wake_event,
    output logic [2:0] pll_out_divider,
    output logic [2:0] fast_rc_divider,
    output logic [1:0] periph_bus_divisor,
    output logic [2:0] pll_multiplier,
    output logic [2:0] requested_source_sel,
    output logic secondary_osc_enable,
    output logic pll_out_tick,
    output logic fast_rc_tick,
    output logic periph_bus_clock,
    output logic sleep_mode,
    output logic idle_mode
);
    import oscc_pkg::*;

    // ******************************
    // eight-step divide decode
    // ******************************
    function automatic logic [8:0] div_ratio(input logic [2:0] code);
        logic [8:0] r;
        r = OSCC_DIV_ONE << code;
        if (code == 3'h7) begin
            r = OSCC_DIV_ONE << 8;
        end
        return r;
    endfunction

    typedef struct packed {
        logic [2:0] s0;
        logic [2:0] s1;
        logic [2:0] s2;
        logic [2:0] s3;
        logic [2:0] s4;
    } oscc_sync_t;

    typedef struct packed {
        logic loaded;
        logic [2:0] odiv;
        logic [2:0] fdiv;
        logic [1:0] pdiv;
        logic [2:0] mult;
        logic [2:0] req;
        logic lock;
        logic slp;
        logic sen;
        logic [3:0] settle;
        oscc_unl_t unl;
        oscc_pwr_t pwr;
        oscc_sync_t sy1;
        oscc_sync_t sy2;
        logic [31:0] rdata;
        logic ready;
        logic err;
        logic pb_clk;
        logic sleep;
        logic idle;
    } oscc_state_t;

    oscc_state_t state;
    oscc_state_t next_state;
    logic pll_tick;
    logic frc_tick;
    logic pb_tick;
    logic locked;
    logic setup;
    logic access;

    // ******************************
    // clock enables
    // ******************************
    oscc_clk_div u_pll_div (
        .pclk(pclk), .presetn(presetn),
        .ratio(div_ratio(state.odiv)), .tick(pll_tick)
    );
    oscc_clk_div u_frc_div (
        .pclk(pclk), .presetn(presetn),
        .ratio(div_ratio(state.fdiv)), .tick(frc_tick)
    );
    oscc_clk_div #(.CW(4)) u_pb_div (
        .pclk(pclk), .presetn(presetn),
        .ratio(4'(OSCC_DIV_ONE << state.pdiv)), .tick(pb_tick)
    );

    always_comb begin
        locked = state.lock && switch_monitor_cfg[1];
        setup = psel && !penable;
        access = psel && penable && state.ready;
    end

    // ******************************
    // next state
    // ******************************
    always_comb begin
        next_state = state;
        next_state.ready = 1'b0;
        next_state.err = 1'b0;
        next_state.sy1 = {3'(secondary_osc_stable), 3'(usb_pll_lock_in),
            3'(system_pll_lock_in), active_source_in, 3'(wake_event)};
        next_state.sy2 = state.sy1;
        next_state.pb_clk = state.pb_clk ^ pb_tick;
        if (!state.loaded) begin
            next_state.loaded = 1'b1;
            next_state.odiv = cfg_pll_out_divider;
            next_state.pdiv = cfg_periph_bus_divisor;
            next_state.mult = cfg_pll_multiplier;
            next_state.req = boot_source_cfg;
            next_state.sen = cfg_secondary_osc_enable;
        end
        if (state.settle != '0) begin
            next_state.settle = state.settle - 4'h1;
        end
        if (setup) begin
            next_state.ready = 1'b1;
            next_state.err = (paddr != OSCC_ADDR_CTRL) && (paddr != OSCC_ADDR_STROBE);
            next_state.rdata = OSCC_ZERO;
            if (paddr == OSCC_ADDR_CTRL && !pwrite) begin
                next_state.rdata[OSCC_POS_ODIV +: 3] = state.odiv;
                next_state.rdata[OSCC_POS_FDIV +: 3] = state.fdiv;
                next_state.rdata[OSCC_POS_SRDY] = state.sy2.s0[0];
                next_state.rdata[OSCC_POS_PRDY] = (state.settle == '0);
                next_state.rdata[OSCC_POS_PDIV +: 2] = state.pdiv;
                next_state.rdata[OSCC_POS_MULT +: 3] = state.mult;
                next_state.rdata[OSCC_POS_CUR +: 3] = state.sy2.s3;
                next_state.rdata[OSCC_POS_REQ +: 3] = state.req;
                next_state.rdata[OSCC_POS_LOCK] = state.lock;
                next_state.rdata[OSCC_POS_ULCK] = state.sy2.s1[0];
                next_state.rdata[OSCC_POS_SLCK] = state.sy2.s2[0];
                next_state.rdata[OSCC_POS_SLP] = state.slp;
                next_state.rdata[OSCC_POS_SEN] = state.sen;
            end
        end
        if (access) begin
            if (pwrite && paddr == OSCC_ADDR_STROBE) begin
                next_state.unl = OSCC_UNL_IDLE;
                if (pwdata == OSCC_UNLOCK_KEY1) begin
                    next_state.unl = OSCC_UNL_KEY1;
                end else if (pwdata == OSCC_UNLOCK_KEY2 && state.unl == OSCC_UNL_KEY1) begin
                    next_state.unl = OSCC_UNL_OPEN;
                end
                if (pwdata[OSCC_POS_WAIT] && state.pwr == OSCC_RUN) begin
                    next_state.pwr = OSCC_WAIT;
                end
            end
            if (pwrite && paddr == OSCC_ADDR_CTRL && state.unl == OSCC_UNL_OPEN) begin
                next_state.fdiv = pwdata[OSCC_POS_FDIV +: 3];
                next_state.slp = pwdata[OSCC_POS_SLP];
                next_state.sen = pwdata[OSCC_POS_SEN];
                next_state.lock = pwdata[OSCC_POS_LOCK] | state.lock;
                if (!locked) begin
                    next_state.odiv = pwdata[OSCC_POS_ODIV +: 3];
                    next_state.mult = pwdata[OSCC_POS_MULT +: 3];
                    next_state.req = pwdata[OSCC_POS_REQ +: 3];
                end
                if (!locked && state.settle == '0 &&
                    pwdata[OSCC_POS_PDIV +: 2] != state.pdiv) begin
                    next_state.pdiv = pwdata[OSCC_POS_PDIV +: 2];
                    next_state.settle = 4'(OSCC_PDIV_SETTLE);
                end
            end
        end
        if (!switch_monitor_cfg[1]) begin
            next_state.lock = 1'b0;
        end
        if (wait_exec && state.pwr == OSCC_RUN) begin
            next_state.pwr = OSCC_WAIT;
        end
        case (state.pwr)
            OSCC_RUN: begin
                next_state.sleep = 1'b0;
                next_state.idle = 1'b0;
            end
            OSCC_WAIT: begin
                next_state.sleep = state.slp;
                next_state.idle = !state.slp;
                if (state.sy2.s4[0]) begin
                    next_state.pwr = OSCC_RUN;
                end
            end
            default: begin
                next_state.pwr = OSCC_RUN;
            end
        endcase
    end

    // ******************************
    // registers
    // ******************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= '0;
            state.fdiv <= OSCC_FDIV_RST;
            state.unl <= OSCC_UNL_IDLE;
            state.pwr <= OSCC_RUN;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_out_tick <= 1'b0;
            fast_rc_tick <= 1'b0;
        end else begin
            pll_out_tick <= pll_tick;
            fast_rc_tick <= frc_tick;
        end
    end

    assign prdata = state.rdata;
    assign pready = state.ready;
    assign pslverr = state.err;
    assign pll_out_divider = state.odiv;
    assign fast_rc_divider = state.fdiv;
    assign periph_bus_divisor = state.pdiv;
    assign pll_multiplier = state.mult;
    assign requested_source_sel = state.req;
    assign secondary_osc_enable = state.sen;
    assign periph_bus_clock = state.pb_clk;
    assign sleep_mode = state.sleep;
    assign idle_mode = state.idle;
endmodule // oscc_ctrl
`default_nettype wire

// [test/oscc_ctrl_chk.sv]
// checker: bus answer, readback and divisor timing assertions
`default_nettype none
module oscc_ctrl_chk
    import oscc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [oscc_pkg::OSCC_ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic [2:0] pll_out_divider,
    input wire logic [2:0] fast_rc_divider,
    input wire logic [1:0] periph_bus_divisor,
    input wire logic [2:0] pll_multiplier,
    input wire logic [2:0] requested_source_sel,
    input wire logic sleep_mode,
    input wire logic idle_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic rd = pready && !pwrite && paddr == OSCC_ADDR_CTRL;
    wire logic wr = psel && penable && pready && pwrite && paddr == OSCC_ADDR_CTRL;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ****************************************
    // assertions
    // ****************************************
    AST_ANSWER: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    AST_ZERO: assert property (rd |-> {prdata[31:30], prdata[23], prdata[15], prdata[11]} == 5'h00)
        else $error("unused bits not zero");
    AST_ODIV: assert property (rd |-> prdata[29:27] == pll_out_divider)
        else $error("output divider readback");
    AST_FDIV: assert property (rd |-> prdata[26:24] == fast_rc_divider)
        else $error("rc divider readback");
    AST_PDIV: assert property (rd |-> prdata[20:19] == periph_bus_divisor)
        else $error("bus divisor readback");
    AST_MULT: assert property (rd |-> prdata[18:16] == pll_multiplier)
        else $error("multiplier readback");
    AST_REQ: assert property (rd |-> prdata[10:8] == requested_source_sel)
        else $error("requested source readback");
    AST_WAIT: assert property (!(sleep_mode && idle_mode))
        else $error("sleep and idle together");
    AST_PSRC: assert property ($changed(periph_bus_divisor) |-> !$past(presetn, 2) || $past(wr))
        else $error("divisor changed without write");
    AST_SETTLE: assert property ($changed(periph_bus_divisor) && $past(presetn, 2)
        |=> $stable(periph_bus_divisor)[*8])
        else $error("divisor changed while not ready");
endmodule // oscc_ctrl_chk
bind oscc_ctrl oscc_ctrl_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .prdata, .pready, .pll_out_divider, .fast_rc_divider, .periph_bus_divisor,
    .pll_multiplier, .requested_source_sel, .sleep_mode, .idle_mode);
`default_nettype wire

// [test/oscc_ctrl_tb.sv]
// testbench: config load, unlock, fields, status, wait and lock
`default_nettype none
module oscc_ctrl_tb;
    import oscc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] MSK = 32'hFFFF_FFF3;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, wait_exec = 0;
    logic wake_event = 0, cfg_secondary_osc_enable = 1, secondary_osc_stable = 0;
    logic usb_pll_lock_in = 0, system_pll_lock_in = 0, pready, pslverr, errv;
    logic secondary_osc_enable, pll_out_tick, fast_rc_tick, periph_bus_clock;
    logic sleep_mode, idle_mode;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rdv;
    logic [2:0] cfg_pll_out_divider = 3'h5, cfg_pll_multiplier = 3'h6;
    logic [2:0] boot_source_cfg = 3'h3, active_source_in = 3'h0;
    logic [2:0] pll_out_divider, fast_rc_divider, pll_multiplier, requested_source_sel;
    logic [1:0] cfg_periph_bus_divisor = 2'h2, switch_monitor_cfg = 2'h0, periph_bus_divisor;
    int n_fail = 0, n_compared = 0;
    oscc_ctrl u_oscc_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .cfg_pll_out_divider, .cfg_periph_bus_divisor,
        .cfg_pll_multiplier, .boot_source_cfg, .cfg_secondary_osc_enable, .switch_monitor_cfg,
        .secondary_osc_stable, .usb_pll_lock_in, .system_pll_lock_in, .active_source_in,
        .wait_exec, .wake_event, .pll_out_divider, .fast_rc_divider, .periph_bus_divisor,
        .pll_multiplier, .requested_source_sel, .secondary_osc_enable, .pll_out_tick,
        .fast_rc_tick, .periph_bus_clock, .sleep_mode, .idle_mode);
    initial begin
        forever #20 pclk = ~pclk;
    end
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic results;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i >= 20) begin
            n_fail++;
            results;
        end
    endtask
    task automatic unl;
        apb(OSCC_ADDR_STROBE, 1'b1, OSCC_UNLOCK_KEY1);
        apb(OSCC_ADDR_STROBE, 1'b1, OSCC_UNLOCK_KEY2);
    endtask
    task automatic t_write;
        apb(OSCC_ADDR_CTRL, 1'b0, 32'h0);
        chk("reset", 32'h2936_0302, rdv & MSK);
        apb(OSCC_ADDR_CTRL, 1'b1, 32'h0000_0700);
        apb(OSCC_ADDR_CTRL, 1'b0, 32'h0);
        chk("no unlock", 32'h2936_0302, rdv & MSK);
        unl;
        apb(OSCC_ADDR_CTRL, 1'b1, 32'hF887_8D10);
        apb(OSCC_ADDR_CTRL, 1'b0, 32'h0);
        chk("fields", 32'h3807_0510, rdv & MSK);
        apb(OSCC_ADDR_CTRL, 1'b1, 32'h381F_0510);
        repeat (12) @(posedge pclk);
        apb(OSCC_ADDR_CTRL, 1'b0, 32'h0);
        chk("pdiv hold", 32'h3827_0510, rdv & MSK);
        $display("write test done");
    endtask
    task automatic t_tick;
        int a;
        int b;
        int c;
        a = 0;
        b = 0;
        c = 0;
        repeat (512) begin
            @(negedge pclk);
            a += pll_out_tick;
            b += fast_rc_tick;
            c += periph_bus_clock;
        end
        chk("pll ticks", 2, a);
        chk("rc ticks", 512, b);
        chk("bus clock", 256, c);
        $display("tick test done");
    endtask
    task automatic stat(input logic s, u, y, input logic [2:0] c, input logic [31:0] e);
        @(posedge pclk);
        secondary_osc_stable <= s;
        usb_pll_lock_in <= u;
        system_pll_lock_in <= y;
        active_source_in <= c;
        repeat (5) @(posedge pclk);
        apb(OSCC_ADDR_CTRL, 1'b0, 32'h0);
        chk("status", e, rdv & 32'h0040_7060);
        $display("status test done");
    endtask
    task automatic slp(input logic [31:0] v, input logic [1:0] e, input logic x);
        unl;
        apb(OSCC_ADDR_CTRL, 1'b1, v);
        if (x) begin
            @(posedge pclk);
            wait_exec <= 1'b1;
            @(posedge pclk);
            wait_exec <= 1'b0;
        end else begin
            apb(OSCC_ADDR_STROBE, 1'b1, 32'h2);
        end
        repeat (2) @(negedge pclk);
        chk("wait", e, {sleep_mode, idle_mode});
        @(posedge pclk);
        wake_event <= 1'b1;
        repeat (6) @(posedge pclk);
        wake_event <= 1'b0;
        @(negedge pclk);
        chk("wake", 2'b00, {sleep_mode, idle_mode});
        $display("wait test done");
    endtask
    task automatic t_lock;
        switch_monitor_cfg <= 2'b10;
        unl;
        apb(OSCC_ADDR_CTRL, 1'b1, 32'h3807_0580);
        apb(OSCC_ADDR_CTRL, 1'b1, 32'h3807_0280);
        apb(OSCC_ADDR_CTRL, 1'b0, 32'h0);
        chk("locked", 32'h0000_0500, rdv & 32'h0000_0700);
        switch_monitor_cfg <= 2'b00;
        apb(OSCC_ADDR_CTRL, 1'b1, 32'h3807_0280);
        apb(OSCC_ADDR_CTRL, 1'b0, 32'h0);
        chk("unlocked", 32'h0000_0200, rdv & 32'h0000_0700);
        apb(8'h08, 1'b0, 32'h0);
        chk("unmapped", 1'b1, errv);
        $display("lock test done");
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (10) @(posedge pclk);
        t_write;
        t_tick;
        stat(1'b1, 1'b1, 1'b0, 3'h6, 32'h0040_6040);
        stat(1'b0, 1'b0, 1'b1, 3'h1, 32'h0000_1020);
        slp(32'h3807_0510, 2'b10, 1'b0);
        slp(32'h3807_0500, 2'b01, 1'b1);
        t_lock;
        results;
    end
endmodule // oscc_ctrl_tb
`default_nettype wire
